// ### inc/loop_cfg_consts.svh
// constants for the loop factor configuration registers
`ifndef LOOP_CFG_CONSTS_SVH
`define LOOP_CFG_CONSTS_SVH
`define OFS_REF_PIN_SELECT 8'h12
`define OFS_PRE_DIVIDER 8'h14
`define OFS_INTEGER_FACTOR 8'h15
`define OFS_FRACTION_HIGH 8'h16
`define OFS_FRACTION_LOW 8'h17
`define OFS_R_FACTOR 8'h18
`define OFS_PROC_CLOCK_DIVIDER 8'h1B
`define RST_REF_PIN_SELECT 3'h0
`define RST_PRE_DIVIDER 4'h0
`define RST_INTEGER_FACTOR 6'h08
`define RST_FRACTION_HIGH 6'h00
`define RST_FRACTION_LOW 8'h00
`define RST_R_FACTOR 4'h0
`define RST_PROC_CLOCK_DIVIDER 7'h00
`define REF_CODE_PIN_ZERO 3'h3
`define REF_CODE_PIN_TWO 3'h5
`define FRACTION_MAX 14'h270F
`define AUTO_PRE_DIVIDE 5'h01
`define AUTO_INTEGER 6'h08
`define AUTO_FRACTION 14'h0000
`define AUTO_R 5'h01
`define AUTO_PROC_DIVIDE 8'h01
`define OUT_RST_PRE_DIVIDE 5'h01
`define OUT_RST_FRACTION 14'h0000
`define OUT_RST_R 5'h01
`define OUT_RST_PROC_DIVIDE 8'h01
`endif

// ### inc/loop_cfg_pkg.sv
// types for the loop factor configuration registers
package loop_cfg_pkg;
  typedef enum logic [1:0] {
    REF_NONE,
    REF_PIN_ZERO,
    REF_PIN_TWO
  } ref_route_t;
endpackage

// ### inc/loop_factor_if.sv
// factor fields handed from the register file to the factor decoder
`timescale 1ns/100ps
interface loop_factor_if;
  logic [2:0] ref_code;
  logic [3:0] pre_code;
  logic [5:0] int_code;
  logic [13:0] frac_code;
  logic [3:0] r_code;
  logic [6:0] proc_code;
  logic auto_mode;
  loop_cfg_pkg::ref_route_t route;
  logic [4:0] pre_div;
  logic [5:0] int_mult;
  logic [13:0] frac_mult;
  logic [4:0] r_mult;
  logic [7:0] proc_div;
  logic frac_bad;
  modport regs (output ref_code, pre_code, int_code, frac_code, r_code, proc_code, auto_mode,
    input route, pre_div, int_mult, frac_mult, r_mult, proc_div, frac_bad);
  modport dec (input ref_code, pre_code, int_code, frac_code, r_code, proc_code, auto_mode,
    output route, pre_div, int_mult, frac_mult, r_mult, proc_div, frac_bad);
endinterface

// ### hw/loop_factor_decode.sv
// decodes factor codes into effective loop factors
`timescale 1ns/100ps
`include "loop_cfg_consts.svh"
module loop_factor_decode (
  loop_factor_if.dec f
);
  // code plus one, shared by the pre divider, the R factor and the processor divider
  function automatic logic [7:0] plus_one(input logic [6:0] code);
    plus_one = {1'b0, code} + 8'h01;
  endfunction

  wire [7:0] pre_full = plus_one({3'h0, f.pre_code});
  wire [7:0] r_full = plus_one({3'h0, f.r_code});
  wire [7:0] proc_full = plus_one(f.proc_code);

  // only two codes reach a pin, the rest mute the reference
  assign f.route = (f.ref_code == `REF_CODE_PIN_ZERO) ? loop_cfg_pkg::REF_PIN_ZERO :
    (f.ref_code == `REF_CODE_PIN_TWO) ? loop_cfg_pkg::REF_PIN_TWO :
    loop_cfg_pkg::REF_NONE;
  assign f.pre_div = f.auto_mode ? `AUTO_PRE_DIVIDE : pre_full[4:0];
  assign f.int_mult = f.auto_mode ? `AUTO_INTEGER : f.int_code;
  assign f.frac_mult = f.auto_mode ? `AUTO_FRACTION : f.frac_code;
  assign f.r_mult = f.auto_mode ? `AUTO_R : r_full[4:0];
  assign f.proc_div = f.auto_mode ? `AUTO_PROC_DIVIDE : proc_full;
  // flagged only, software owns keeping it legal
  assign f.frac_bad = f.frac_code > `FRACTION_MAX;
endmodule

// ### hw/pll_factor_config_regs.sv
// loop factor configuration register group with decoded factor outputs
// Function
// - codes 011/101 pick pin; others mute
// - pre-divide equals code plus one
// - integer factor equals code, resets eight
// - multiplication is integer.fraction times R
// - fraction split high six, low eight
// - auto setup ignores factor fields, except pin route and fraction flag
// - pre, fraction, pin select reset zero
// - processor divider code plus one, 1-128
`timescale 1ns/100ps
`include "loop_cfg_consts.svh"
module pll_factor_config_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control port register access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // automatic clock setup mode level
  input wire logic auto_mode,
  // decoded loop settings
  output loop_cfg_pkg::ref_route_t ref_route,
  output logic mute_ref,
  output logic [4:0] pre_divide,
  output logic [5:0] integer_mult,
  output logic [13:0] fraction_mult,
  output logic [4:0] r_mult,
  output logic [7:0] processor_divide,
  output logic fraction_illegal
);
  // ----------------------------------------
  // field storage
  // ----------------------------------------
  logic [2:0] loop_ref_pin_select_reg;
  logic [3:0] loop_pre_divider_reg;
  logic [5:0] loop_integer_factor_reg;
  logic [5:0] fraction_high_reg;
  logic [7:0] fraction_low_reg;
  logic [3:0] loop_r_factor_reg;
  logic [6:0] processor_clock_divider_reg;
  logic [7:0] rd_data_next;
  logic rd_hit_next;
  // auto mode may come from another block's clock, so it is synchronised
  logic auto_mode_s1;
  logic auto_mode_s2;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire sel_ref = addr == `OFS_REF_PIN_SELECT;
  wire sel_pre = addr == `OFS_PRE_DIVIDER;
  wire sel_int = addr == `OFS_INTEGER_FACTOR;
  wire sel_fh = addr == `OFS_FRACTION_HIGH;
  wire sel_fl = addr == `OFS_FRACTION_LOW;
  wire sel_r = addr == `OFS_R_FACTOR;
  wire sel_proc = addr == `OFS_PROC_CLOCK_DIVIDER;
  wire any_sel = sel_ref | sel_pre | sel_int | sel_fh | sel_fl | sel_r | sel_proc;
  // unmapped offsets never match, so their writes fall away
  wire wr_ref = wr_en & sel_ref;
  wire wr_pre = wr_en & sel_pre;
  wire wr_int = wr_en & sel_int;
  wire wr_fh = wr_en & sel_fh;
  wire wr_fl = wr_en & sel_fl;
  wire wr_r = wr_en & sel_r;
  wire wr_proc = wr_en & sel_proc;

  // ----------------------------------------
  // writes, one register each
  // ----------------------------------------
  // illegal codes are stored as written; the host keeps them out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_ref_pin_select_reg <= `RST_REF_PIN_SELECT;
    end else if (wr_ref) begin
      loop_ref_pin_select_reg <= wr_data[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_pre_divider_reg <= `RST_PRE_DIVIDER;
    end else if (wr_pre) begin
      loop_pre_divider_reg <= wr_data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_integer_factor_reg <= `RST_INTEGER_FACTOR;
    end else if (wr_int) begin
      loop_integer_factor_reg <= wr_data[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fraction_high_reg <= `RST_FRACTION_HIGH;
    end else if (wr_fh) begin
      fraction_high_reg <= wr_data[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fraction_low_reg <= `RST_FRACTION_LOW;
    end else if (wr_fl) begin
      fraction_low_reg <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_r_factor_reg <= `RST_R_FACTOR;
    end else if (wr_r) begin
      loop_r_factor_reg <= wr_data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      processor_clock_divider_reg <= `RST_PROC_CLOCK_DIVIDER;
    end else if (wr_proc) begin
      processor_clock_divider_reg <= wr_data[6:0];
    end
  end

  // ----------------------------------------
  // reads, reserved bits return zero
  // ----------------------------------------
  assign rd_data_next =
    sel_ref ? {5'h00, loop_ref_pin_select_reg} :
    sel_pre ? {4'h0, loop_pre_divider_reg} :
    sel_int ? {2'h0, loop_integer_factor_reg} :
    sel_fh ? {2'h0, fraction_high_reg} :
    sel_fl ? fraction_low_reg :
    sel_r ? {4'h0, loop_r_factor_reg} :
    sel_proc ? {1'h0, processor_clock_divider_reg} : 8'h00;
  assign rd_hit_next = rd_en & any_sel;

  // ----------------------------------------
  // factor decode
  // ----------------------------------------
  loop_factor_if fif ();
  assign fif.ref_code = loop_ref_pin_select_reg;
  assign fif.pre_code = loop_pre_divider_reg;
  assign fif.int_code = loop_integer_factor_reg;
  assign fif.frac_code = {fraction_high_reg, fraction_low_reg};
  assign fif.r_code = loop_r_factor_reg;
  assign fif.proc_code = processor_clock_divider_reg;
  assign fif.auto_mode = auto_mode_s2;

  loop_factor_decode u_dec (
    .f(fif)
  );

  // ----------------------------------------
  // auto mode synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_mode_s1 <= 1'b0;
      auto_mode_s2 <= 1'b0;
    end else begin
      auto_mode_s1 <= auto_mode;
      auto_mode_s2 <= auto_mode_s1;
    end
  end

  // ----------------------------------------
  // registered read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_hit <= 1'b0;
    end else begin
      rd_data <= rd_en ? rd_data_next : 8'h00;
      rd_hit <= rd_hit_next;
    end
  end

  // ----------------------------------------
  // registered reference route
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_route <= loop_cfg_pkg::REF_NONE;
      mute_ref <= 1'b1;
    end else begin
      ref_route <= fif.route;
      mute_ref <= fif.route == loop_cfg_pkg::REF_NONE;
    end
  end

  // ----------------------------------------
  // registered factors; J, D and R leave together so the loop sees J.D * R
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_divide <= `OUT_RST_PRE_DIVIDE;
      integer_mult <= `RST_INTEGER_FACTOR;
      fraction_mult <= `OUT_RST_FRACTION;
      r_mult <= `OUT_RST_R;
    end else begin
      pre_divide <= fif.pre_div;
      integer_mult <= fif.int_mult;
      fraction_mult <= fif.frac_mult;
      r_mult <= fif.r_mult;
    end
  end

  // ----------------------------------------
  // processor divider and fraction flag
  // ----------------------------------------
  // the flag is advisory only; nothing here blocks an illegal fraction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      processor_divide <= `OUT_RST_PROC_DIVIDE;
      fraction_illegal <= 1'b0;
    end else begin
      processor_divide <= fif.proc_div;
      fraction_illegal <= fif.frac_bad;
    end
  end
endmodule

// ### testbench/loop_cfg_monitor.sv
// assertion checker for the loop factor register ports
`timescale 1ns/100ps
module loop_cfg_monitor (
  input wire logic clk, rst_n, wr_en, rd_en, auto_mode, rd_hit, mute_ref,
  input wire logic [7:0] addr, wr_data, processor_divide,
  input wire logic [4:0] pre_divide, r_mult,
  input wire logic [5:0] integer_mult,
  input wire logic [13:0] fraction_mult,
  input wire loop_cfg_pkg::ref_route_t ref_route
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // auto level history covers the synchroniser delay
  logic [3:0] auto_hist;
  always_ff @(posedge clk) begin
    auto_hist <= rst_n ? {auto_hist[2:0], auto_mode} : 4'h0;
  end
  wire quiet = auto_hist == 4'h0 && !auto_mode;
  wire wr_q = wr_en && quiet;
  mute_route_a: assert property (mute_ref == (ref_route == loop_cfg_pkg::REF_NONE))
    else $error("mute disagrees with route");
  route_code_a: assert property (wr_en && addr == 8'h12 |-> ##2 ref_route ==
    ($past(wr_data[2:0], 2) == 3'h3 ? loop_cfg_pkg::REF_PIN_ZERO :
    $past(wr_data[2:0], 2) == 3'h5 ? loop_cfg_pkg::REF_PIN_TWO : loop_cfg_pkg::REF_NONE))
    else $error("bad route");
  pre_code_a: assert property (wr_q && addr == 8'h14 |-> ##2
    pre_divide == $past(wr_data[3:0], 2) + 5'h01) else $error("bad pre divide");
  int_code_a: assert property (wr_q && addr == 8'h15 |-> ##2
    integer_mult == $past(wr_data[5:0], 2)) else $error("bad integer factor");
  frac_low_a: assert property (wr_q && addr == 8'h17 |-> ##2
    fraction_mult[7:0] == $past(wr_data, 2)) else $error("bad fraction low");
  r_code_a: assert property (wr_q && addr == 8'h18 |-> ##2
    r_mult == $past(wr_data[3:0], 2) + 5'h01) else $error("bad r factor");
  proc_code_a: assert property (wr_q && addr == 8'h1B |-> ##2
    processor_divide == $past(wr_data[6:0], 2) + 8'h01) else $error("bad processor divide");
  auto_fixed_a: assert property (auto_hist == 4'hF && auto_mode |-> pre_divide == 5'h01 &&
    integer_mult == 6'h08 && fraction_mult == 14'h0000 && r_mult == 5'h01 &&
    processor_divide == 8'h01) else $error("auto values wrong");
  pin_c: cover property (wr_en && addr == 8'h12);
  auto_c: cover property (auto_hist == 4'hF);
  read_c: cover property (rd_hit);
endmodule

// ### testbench/loop_host.sv
// host model driving the control port
`timescale 1ns/100ps
module loop_host (
  input wire logic clk,
  output logic wr_en, rd_en,
  output logic [7:0] addr, wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // callers pass only legal factor codes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
    h = rd_hit;
  endtask
endmodule

// ### testbench/pll_factor_config_regs_tb.sv
// self-checking bench for the loop factor register group
`timescale 1ns/100ps
module pll_factor_config_regs_tb;
  logic clk = 0, rst_n = 0, auto_mode = 0, wr_en, rd_en, rd_hit, mute_ref, fraction_illegal, hit;
  logic [7:0] addr, wr_data, rd_data, processor_divide, v;
  logic [4:0] pre_divide, r_mult;
  logic [5:0] integer_mult;
  logic [13:0] fraction_mult;
  loop_cfg_pkg::ref_route_t ref_route;
  int errors = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  pll_factor_config_regs dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .auto_mode(auto_mode),
    .ref_route(ref_route), .mute_ref(mute_ref), .pre_divide(pre_divide), .r_mult(r_mult),
    .integer_mult(integer_mult), .fraction_mult(fraction_mult),
    .processor_divide(processor_divide), .fraction_illegal(fraction_illegal));
  loop_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_hit(rd_hit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] ofs [7] = '{8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B};
    chk({mute_ref, pre_divide, integer_mult, fraction_mult}, {1'b1, 5'h01, 6'h08, 14'h0});
    for (int i = 0; i < 7; i++) begin
      host.rd(ofs[i], v, hit);
      chk({v, hit}, {(ofs[i] == 8'h15 ? 8'h08 : 8'h00), 1'b1});
    end
    host.rd(8'h13, v, hit);
    chk({v, hit}, 9'h000);
    $display("reset test done");
  endtask
  task automatic t_pin;
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h12, 8'hF8 | 8'(c));
      @(posedge clk);
      #1;
      chk(ref_route, c == 3 ? 1 : c == 5 ? 2 : 0);
      chk(mute_ref, c != 3 && c != 5);
      host.rd(8'h12, v, hit);
      chk(v, c);
    end
    $display("pin test done");
  endtask
  task automatic t_factors;
    for (int k = 0; k < 2; k++) begin
      host.wr(8'h14, k ? 8'h0E : 8'h00);
      host.wr(8'h15, k ? 8'h3F : 8'h01);
      host.wr(8'h16, k ? 8'h27 : 8'h00);
      host.wr(8'h17, k ? 8'h0F : 8'h01);
      host.wr(8'h18, k ? 8'h0F : 8'h00);
      host.wr(8'h1B, k ? 8'h7F : 8'h00);
      @(posedge clk);
      #1;
      chk(pre_divide, k ? 15 : 1);
      chk(integer_mult, k ? 63 : 1);
      chk({fraction_mult, fraction_illegal}, {(k ? 14'h270F : 14'h0001), 1'b0});
      chk(r_mult, k ? 16 : 1);
      chk(processor_divide, k ? 128 : 1);
    end
    $display("factor test done");
  endtask
  task automatic t_auto;
    @(posedge clk);
    auto_mode <= 1'b1;
    repeat (4) @(posedge clk);
    host.wr(8'h15, 8'h05);
    chk({pre_divide, integer_mult, fraction_mult}, {5'h01, 6'h08, 14'h0});
    chk({r_mult, processor_divide}, {5'h01, 8'h01});
    @(posedge clk);
    auto_mode <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({pre_divide, integer_mult, r_mult}, {5'h0F, 6'h05, 5'h10});
    $display("auto test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_pin;
    t_factors;
    t_auto;
    report_and_stop;
  end
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      report_and_stop;
    end
  end
endmodule
bind pll_factor_config_regs loop_cfg_monitor mon (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
  .rd_en(rd_en), .auto_mode(auto_mode), .rd_hit(rd_hit), .mute_ref(mute_ref), .addr(addr),
  .wr_data(wr_data), .processor_divide(processor_divide), .pre_divide(pre_divide),
  .r_mult(r_mult), .integer_mult(integer_mult), .fraction_mult(fraction_mult),
  .ref_route(ref_route));
